// ---- rtl/rre_regs.svh ----
/*
  Constants of the return and rotate execution block: opcode patterns,
  flag bit positions, bank mapping, phase counts and reset values.
  Assumes it is included by bare name from the package and from rre_exec.
*/
`ifndef RRE_REGS_SVH
`define RRE_REGS_SVH

// ==========================================================================
// Opcode patterns
`define RRE_RET_MASK 16'hfffe
`define RRE_RET_PAT 16'h0012
`define RRE_RLC_TOP 6'h0d
`define RRE_RLN_TOP 6'h11

// ==========================================================================
// Opcode field positions
`define RRE_QUICK_BIT 0
`define RRE_TARGET_BIT 9
`define RRE_BANKSEL_BIT 8

// ==========================================================================
// Flag register layout
`define RRE_FLAG_C 0
`define RRE_FLAG_DC 1
`define RRE_FLAG_Z 2
`define RRE_FLAG_OV 3
`define RRE_FLAG_N 4

// ==========================================================================
// Quick-access bank mapping
`define RRE_ACCESS_SPLIT 8'h80
`define RRE_ACCESS_LO_BANK 4'h0
`define RRE_ACCESS_HI_BANK 4'hf

// ==========================================================================
// Phase counts
`define RRE_Q1 2'h0
`define RRE_Q2 2'h1
`define RRE_Q3 2'h2
`define RRE_Q4 2'h3

// ==========================================================================
// Reset values
`define RRE_ACC_RST 8'h00
`define RRE_FLAGS_RST 5'h00
`define RRE_BSR_RST 4'h0
`define RRE_PC_RST 21'h000000
`define RRE_ADDR_RST 12'h000

`endif

// ---- rtl/rre_pkg.sv ----
/*
  Types of the return and rotate execution block.
  Assumes rre_regs.svh is on the include path.
*/
`include "rre_regs.svh"

package rre_pkg;

  // ========================================================================
  // Operation in flight
  typedef enum logic [1:0] {
    RRE_IDLE,
    RRE_RET,
    RRE_RLC,
    RRE_RLN
  } rre_op_t;

  // ========================================================================
  // Whole state of the execution unit
  typedef struct packed {
    logic [1:0] q;
    rre_op_t op;
    logic nop_cycle;
    logic quick;
    logic to_file;
    logic [7:0] operand;
    logic [7:0] acc;
    logic [4:0] flags;
    logic [3:0] bank_select_reg;
    logic ready;
    logic [11:0] file_addr;
    logic file_re;
    logic file_we;
    logic [7:0] file_wdata;
    logic pc_load;
    logic [20:0] pc_value;
    logic stack_pop;
    logic ignored;
  } rre_state_t;

endpackage

// ---- rtl/rre_rotate.sv ----
/*
  Single-bit left rotator, with or without the carry in the loop.
  Purely combinational; the caller registers every result.
*/
`timescale 1ns/10ps
`default_nettype none

module rre_rotate (
  // Operand
  input wire logic [7:0] i_operand,
  input wire logic i_carry_in,
  input wire logic i_via_carry,
  // Result
  output logic [7:0] o_result,
  output logic o_carry_out,
  output logic o_negative,
  output logic o_zero
);

  // ========================================================================
  // Rotate
  always_comb begin
    if (i_via_carry) begin
      o_result = {i_operand[6:0], i_carry_in};
    end else begin
      o_result = {i_operand[6:0], i_operand[7]};
    end
    o_carry_out = i_operand[7];
    o_negative = o_result[7];
    o_zero = (o_result == 8'h00);
  end

endmodule

`default_nettype wire

// ---- rtl/rre_exec.sv ----
/*
  Execution unit for subroutine exit and the two left rotates.
  Assumes a core that offers one opcode per four-phase instruction
  cycle on the same clock, a data memory that answers a read in the
  same cycle, and an external return stack that pops on a pulse.
*/
// Functional notes
// - Decode 0000 0000 0001 001x as subroutine exit
// - Exit pops stack into PC, two cycles
// - Quick bit set: restore accumulator, flags, bank
// - Quick bit clear: shadows leave registers alone
// - Exit touches no PC latch; flags change only with the quick bit set
// - Upper bits 001101 decode rotate through carry
// - Shift left, bit 7 to carry, carry in
// - Carry rotate sets C, N, Z in one cycle
// - Target bit picks accumulator or file register
// - Bank bit picks quick bank or bank register
`timescale 1ns/10ps
`default_nettype none
`include "rre_regs.svh"

module rre_exec (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  // Instruction issue
  input wire logic i_op_valid,
  input wire logic [15:0] i_opcode,
  output logic o_ready,
  output logic o_ignored,
  // Return stack and program counter
  input wire logic [20:0] i_stack_top_entry,
  output logic o_stack_pop,
  output logic o_pc_load,
  output logic [20:0] o_pc_value,
  // Shadow registers
  input wire logic [7:0] i_working_shadow,
  input wire logic [4:0] i_flags_shadow,
  input wire logic [3:0] i_bank_select_shadow,
  // Writes from the rest of the core
  input wire logic i_acc_wr,
  input wire logic [7:0] i_acc_wdata,
  input wire logic i_flags_wr,
  input wire logic [4:0] i_flags_wdata,
  input wire logic i_bsr_wr,
  input wire logic [3:0] i_bsr_wdata,
  // Core registers
  output logic [7:0] o_accumulator_reg,
  output logic [4:0] o_flags_reg,
  output logic [3:0] o_bank_select_reg,
  // Data memory
  output logic [11:0] o_file_addr,
  output logic o_file_re,
  input wire logic [7:0] i_file_rdata,
  output logic o_file_we,
  output logic [7:0] o_file_wdata
);
  import rre_pkg::*;

  rre_state_t s;
  rre_state_t next_s;
  logic [7:0] rot_result;
  logic rot_carry;
  logic rot_neg;
  logic rot_zero;

  // ========================================================================
  // Bank mapping
  function automatic logic [11:0] bank_addr(input logic use_bsr,
                                            input logic [3:0] bank_select_reg,
                                            input logic [7:0] addr);
    logic [3:0] bank;
    bank = bank_select_reg;
    if (!use_bsr) begin
      // Quick bank: low half from bank 0, high half from the top bank
      if (addr < `RRE_ACCESS_SPLIT) begin
        bank = `RRE_ACCESS_LO_BANK;
      end else begin
        bank = `RRE_ACCESS_HI_BANK;
      end
    end
    return {bank, addr};
  endfunction

  // ========================================================================
  // Rotator
  rre_rotate u_rotate (
    .i_operand(s.operand),
    .i_carry_in(s.flags[`RRE_FLAG_C]),
    .i_via_carry(s.op == RRE_RLC),
    .o_result(rot_result),
    .o_carry_out(rot_carry),
    .o_negative(rot_neg),
    .o_zero(rot_zero)
  );

  // ========================================================================
  // Next state
  always_comb begin
    next_s = s;
    next_s.q = s.q + 2'h1;
    next_s.file_re = 1'b0;
    next_s.file_we = 1'b0;
    next_s.pc_load = 1'b0;
    next_s.stack_pop = 1'b0;
    next_s.ignored = 1'b0;
    // Core writes yield to this unit's own writes below
    if (i_acc_wr) begin
      next_s.acc = i_acc_wdata;
    end
    if (i_flags_wr) begin
      next_s.flags = i_flags_wdata;
    end
    if (i_bsr_wr) begin
      next_s.bank_select_reg = i_bsr_wdata;
    end
    case (s.q)
      `RRE_Q1: begin
        if (s.ready && i_op_valid) begin
          next_s.quick = i_opcode[`RRE_QUICK_BIT];
          next_s.to_file = i_opcode[`RRE_TARGET_BIT];
          next_s.file_addr = bank_addr(i_opcode[`RRE_BANKSEL_BIT],
                                       s.bank_select_reg, i_opcode[7:0]);
          if ((i_opcode & `RRE_RET_MASK) == `RRE_RET_PAT) begin
            next_s.op = RRE_RET;
          end else if (i_opcode[15:10] == `RRE_RLC_TOP) begin
            next_s.op = RRE_RLC;
            next_s.file_re = 1'b1;
          end else if (i_opcode[15:10] == `RRE_RLN_TOP) begin
            next_s.op = RRE_RLN;
            next_s.file_re = 1'b1;
          end else begin
            next_s.ignored = 1'b1;
          end
        end
      end
      `RRE_Q2: begin
        if (s.op == RRE_RLC || s.op == RRE_RLN) begin
          next_s.operand = i_file_rdata;
        end
      end
      `RRE_Q3: begin
        case (s.op)
          RRE_RET: begin
            // Pop lands in Q4; PC latches are not this unit's to touch
            next_s.stack_pop = 1'b1;
            next_s.pc_load = 1'b1;
            next_s.pc_value = i_stack_top_entry;
            if (s.quick) begin
              next_s.acc = i_working_shadow;
              next_s.flags = i_flags_shadow;
              next_s.bank_select_reg = i_bank_select_shadow;
            end
            // Quick clear: no shadow copy, flags as before
          end
          RRE_RLC, RRE_RLN: begin
            if (s.to_file) begin
              next_s.file_we = 1'b1;
              next_s.file_wdata = rot_result;
            end else begin
              next_s.acc = rot_result;
            end
            next_s.flags[`RRE_FLAG_N] = rot_neg;
            next_s.flags[`RRE_FLAG_Z] = rot_zero;
            if (s.op == RRE_RLC) begin
              next_s.flags[`RRE_FLAG_C] = rot_carry;
            end
          end
          default: begin
          end
        endcase
      end
      `RRE_Q4: begin
        // Exit spends one more whole cycle doing nothing
        next_s.nop_cycle = (s.op == RRE_RET);
        next_s.op = RRE_IDLE;
      end
      default: begin
      end
    endcase
    next_s.ready = (next_s.q == `RRE_Q1) && !next_s.nop_cycle;
    if (s.q == `RRE_Q4 && s.nop_cycle) begin
      next_s.nop_cycle = 1'b0;
      next_s.ready = 1'b1;
    end
  end

  // ========================================================================
  // State register
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      s <= '{q: `RRE_Q1, op: RRE_IDLE, nop_cycle: 1'b0, quick: 1'b0,
             to_file: 1'b0, operand: 8'h00, acc: `RRE_ACC_RST,
             flags: `RRE_FLAGS_RST, bank_select_reg: `RRE_BSR_RST, ready: 1'b0,
             file_addr: `RRE_ADDR_RST, file_re: 1'b0, file_we: 1'b0,
             file_wdata: 8'h00, pc_load: 1'b0, pc_value: `RRE_PC_RST,
             stack_pop: 1'b0, ignored: 1'b0};
    end else begin
      s <= next_s;
    end
  end

  // ========================================================================
  // Outputs
  assign o_ready = s.ready;
  assign o_ignored = s.ignored;
  assign o_stack_pop = s.stack_pop;
  assign o_pc_load = s.pc_load;
  assign o_pc_value = s.pc_value;
  assign o_accumulator_reg = s.acc;
  assign o_flags_reg = s.flags;
  assign o_bank_select_reg = s.bank_select_reg;
  assign o_file_addr = s.file_addr;
  assign o_file_re = s.file_re;
  assign o_file_we = s.file_we;
  assign o_file_wdata = s.file_wdata;

endmodule

`default_nettype wire

// ---- tb/rre_exec_checker.sv ----
/*
  Port timing checker for rre_exec.
  Assumes a bind to every rre_exec instance; sees its ports only.
*/
`timescale 1ns/10ps
`default_nettype none
module rre_exec_checker (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  // Watched ports
  input wire logic i_op_valid,
  input wire logic [15:0] i_opcode,
  input wire logic o_ready,
  input wire logic o_ignored,
  input wire logic [20:0] i_stack_top_entry,
  input wire logic o_stack_pop,
  input wire logic o_pc_load,
  input wire logic [20:0] o_pc_value,
  input wire logic [7:0] i_working_shadow,
  input wire logic [4:0] i_flags_shadow,
  input wire logic [3:0] i_bank_select_shadow,
  input wire logic [7:0] o_accumulator_reg,
  input wire logic [4:0] o_flags_reg,
  input wire logic [3:0] o_bank_select_reg,
  input wire logic [11:0] o_file_addr,
  input wire logic o_file_re,
  input wire logic o_file_we,
  input wire logic [7:0] o_file_wdata
);
  // ====
  // Decode helpers
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_reset_n);
  wire tk = o_ready && i_op_valid;
  wire ex = tk && i_opcode[15:1] == 15'h0009;
  wire rt = tk && (i_opcode[15:10] == 6'h0d || i_opcode[15:10] == 6'h11);
  wire [3:0] bk = i_opcode[8] ? o_bank_select_reg : {4{i_opcode[7]}};
  wire [11:0] addr_exp = {bk, i_opcode[7:0]};
  // ====
  // Properties
  a_exit_pop: assert property (
    ex |-> ##3 o_stack_pop && o_pc_load &&
    o_pc_value == $past(i_stack_top_entry)) else $error("exit pop");
  a_exit_gap: assert property (
    ex |-> ##1 !o_ready [*7] ##1 o_ready) else $error("exit length");
  a_pop_cause: assert property (
    o_stack_pop |-> $past(ex, 3)) else $error("stray pop");
  a_quick_load: assert property (
    ex && i_opcode[0] |-> ##3
    o_accumulator_reg == $past(i_working_shadow) &&
    o_flags_reg == $past(i_flags_shadow) &&
    o_bank_select_reg == $past(i_bank_select_shadow)) else $error("shadow");
  a_keep_regs: assert property (
    ex && !i_opcode[0] |-> ##3 $stable(o_flags_reg) &&
    $stable(o_accumulator_reg) && $stable(o_bank_select_reg))
    else $error("keep");
  a_rot_file: assert property (
    rt && i_opcode[9] |-> ##1 o_file_re ##2 o_file_we)
    else $error("file write");
  a_rot_acc: assert property (
    rt && !i_opcode[9] |-> ##1 o_file_re ##2 !o_file_we)
    else $error("acc target");
  a_bank_pick: assert property (
    rt |-> ##1 o_file_addr == $past(addr_exp)) else $error("bank");
  a_nz_flags: assert property (
    o_file_we |-> o_flags_reg[4] == o_file_wdata[7] &&
    o_flags_reg[2] == (o_file_wdata == 8'h00)) else $error("n z");
  a_ignore_quiet: assert property (
    o_ignored |-> ##2 !o_file_we && !o_stack_pop)
    else $error("ignored op acted");
  c_quick: cover property (ex && i_opcode[0]);
  c_plain_exit: cover property (ex && !i_opcode[0]);
  c_acc: cover property (rt && !i_opcode[9]);
  c_ign: cover property (o_ignored);
endmodule
bind rre_exec rre_exec_checker u_chk (.*);
`default_nettype wire

// ---- tb/return_and_rotate_exec_tb.sv ----
/*
  Self-checking bench of rre_exec: rotates, exits, unknown codes.
  Assumes the checker file is compiled alongside.
*/
`timescale 1ns/10ps
`default_nettype none
module return_and_rotate_exec_tb;
  // ====
  // Ports and model
  logic i_clk_sys = 0, i_reset_n = 0, i_op_valid = 0;
  logic [15:0] i_opcode = 0;
  logic [20:0] i_stack_top_entry = 0;
  logic [7:0] i_working_shadow = 0, i_acc_wdata = 0, i_file_rdata = 0;
  logic [4:0] i_flags_shadow = 0, i_flags_wdata = 0;
  logic [3:0] i_bank_select_shadow = 0, i_bsr_wdata = 0;
  logic i_acc_wr = 0, i_flags_wr = 0, i_bsr_wr = 0;
  logic o_ready, o_ignored, o_stack_pop, o_pc_load, o_file_re, o_file_we;
  logic [20:0] o_pc_value;
  logic [7:0] o_accumulator_reg, o_file_wdata, m_acc;
  logic [4:0] o_flags_reg, m_fl;
  logic [3:0] o_bank_select_reg, m_bsr;
  logic [11:0] o_file_addr;
  logic [23:0] tbl [6] = '{24'h3612e6, 24'h349080, 24'h462000,
    24'h4533a5, 24'h37ff7f, 24'h370101};
  int fail_count = 0, num_checks = 0;
  rre_exec dut (.*);
  always #12.5 i_clk_sys = ~i_clk_sys;
  // ====
  // Tasks
  task automatic finish_test;
    if (fail_count == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, exp, input string m);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t %s", $time, m);
    end
  endtask
  task automatic tick;
    @(posedge i_clk_sys);
    #1;
  endtask
  // Waits for a take slot; bounded so a stuck unit ends the run
  task automatic issue(input logic [15:0] op);
    int n;
    n = 0;
    while (o_ready !== 1'b1) begin
      tick;
      n++;
      if (n > 20) begin
        chk(0, 1, "no ready");
        finish_test;
      end
    end
    i_op_valid = 1;
    i_opcode = op;
    tick;
    i_op_valid = 0;
  endtask
  task automatic rot(input logic [15:0] op, input logic [7:0] v);
    logic [7:0] r;
    logic [3:0] bk;
    r = {v[6:0], op[14] ? v[7] : m_fl[0]};
    bk = op[8] ? m_bsr : {4{op[7]}};
    i_file_rdata = v;
    issue(op);
    chk(o_file_re, 1, "read");
    chk(o_file_addr, {bk, op[7:0]}, "addr");
    tick;
    i_file_rdata = ~v;
    tick;
    if (!op[14]) m_fl[0] = v[7];
    m_fl[4] = r[7];
    m_fl[2] = (r == 8'h00);
    if (!op[9]) m_acc = r;
    chk(o_file_we, op[9], "we");
    if (op[9]) chk(o_file_wdata, r, "result");
    chk(o_accumulator_reg, m_acc, "acc");
    chk(o_flags_reg, m_fl, "flags");
    tick;
  endtask
  task automatic ret(input logic s, input logic [20:0] top);
    int n;
    i_stack_top_entry = top;
    issue({15'h0009, s});
    tick;
    tick;
    chk({o_stack_pop, o_pc_load}, 2'h3, "pop");
    chk(o_pc_value, top, "pc");
    if (s) {m_acc, m_fl, m_bsr} = {i_working_shadow, i_flags_shadow,
      i_bank_select_shadow};
    chk({o_accumulator_reg, o_flags_reg, o_bank_select_reg},
      {m_acc, m_fl, m_bsr}, "regs");
    // Offer a word during the dead cycle; it must be refused
    i_op_valid = 1;
    i_opcode = 16'hffff;
    n = 0;
    while (o_ready !== 1'b1 && n < 9) begin
      tick;
      n++;
      chk(o_ignored, 0, "refused");
    end
    i_op_valid = 0;
    chk(n, 5, "exit length");
  endtask
  // ====
  // Sequence
  initial begin
    repeat (12) @(posedge i_clk_sys);
    #1;
    chk({o_ready, o_accumulator_reg, o_flags_reg}, 0, "reset");
    i_reset_n = 1;
    {i_acc_wr, i_flags_wr, i_bsr_wr} = 3'h7;
    {i_acc_wdata, i_flags_wdata, i_bsr_wdata} = {8'h3c, 5'h00, 4'h5};
    tick;
    {i_acc_wr, i_flags_wr, i_bsr_wr} = 3'h0;
    {m_acc, m_fl, m_bsr} = {8'h3c, 5'h00, 4'h5};
    foreach (tbl[i]) rot(tbl[i][23:8], tbl[i][7:0]);
    {i_working_shadow, i_flags_shadow, i_bank_select_shadow} =
      {8'ha1, 5'h1b, 4'h9};
    ret(0, 21'h1abcde);
    ret(1, 21'h00345a);
    rot(16'h3533, 8'h40);
    issue(16'h3000);
    chk(o_ignored, 1, "ignored");
    issue(16'h0010);
    chk(o_ignored, 1, "ignored");
    tick;
    tick;
    chk({o_accumulator_reg, o_flags_reg, o_bank_select_reg},
      {m_acc, m_fl, m_bsr}, "unknown kept");
    finish_test;
  end
endmodule
`default_nettype wire
